// ---- dsc_top.sv ----
// Data pins and cycle-define load logic of a two-word burst DDR SRAM
`timescale 1ns/1ps
module dsc_top (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic K_I,
    input wire logic K_N_I,
    input wire logic CYCLE_DEFINE_N_I,
    input wire logic [dsc_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic READ_NOT_WRITE_I,
    input wire logic [dsc_pkg::DATA_W-1:0] DQ_I,
    output logic [dsc_pkg::DATA_W-1:0] DQ_O,
    output logic DQ_OE_O,
    output logic WRITE_STALL_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////
    // Previous samples of the two input clocks
    logic k_prev_reg;
    logic kn_prev_reg;
    // One-cycle enables marking each clock rise
    logic k_rise;
    logic kn_rise;
    // Burst state and its next value
    dsc_pkg::dsc_state_e state_reg;
    dsc_pkg::dsc_state_e state_next;
    // Cycle definition held for the running burst
    dsc_pkg::dsc_cycle_s cycle_reg;
    // A new cycle is defined at this true-clock rise
    logic cycle_start;
    // Both read words fetched at the definition edge
    logic [dsc_pkg::BURST_LEN*dsc_pkg::DATA_W-1:0] rd_burst_reg;
    logic [dsc_pkg::BURST_LEN*dsc_pkg::DATA_W-1:0] rd_burst;
    // Pin output registers
    logic [dsc_pkg::DATA_W-1:0] dq_reg;
    logic dq_oe_reg;
    logic stall_reg;
    // Write capture towards the FIFO
    logic wr_cap;
    dsc_pkg::dsc_wr_word_s wr_word;
    logic fifo_in_ready;
    // FIFO drain towards the array
    logic drain_valid;
    logic drain_ready;
    logic [dsc_pkg::WR_WORD_W-1:0] drain_bits;
    logic [dsc_pkg::WR_WORD_W-1:0] wr_word_bits;
    dsc_pkg::dsc_wr_word_s drain_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////////////////
    // True while the burst in flight is a read
    function automatic logic is_read_state(input dsc_pkg::dsc_state_e st);
        begin
            is_read_state = (st == dsc_pkg::DSC_RD0) || (st == dsc_pkg::DSC_RD1);
        end
    endfunction : is_read_state

    // True while the burst in flight is a write
    function automatic logic is_write_state(input dsc_pkg::dsc_state_e st);
        begin
            is_write_state = (st == dsc_pkg::DSC_WR0) || (st == dsc_pkg::DSC_WR1);
        end
    endfunction : is_write_state

    ////////////////////////////////////////////////////////////////////////////
    // Clock edge detection
    ////////////////////////////////////////////////////////////////////////////
    // Clock pins are taken as synchronous levels, so a plain edge detect suffices
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            // History starts at idle levels, K low and K_N high, so release shows no false rise
            k_prev_reg <= 1'b0;
            kn_prev_reg <= 1'b1;
        end else begin
            k_prev_reg <= K_I;
            kn_prev_reg <= K_N_I;
        end
    end

    // Rising edges only; falling edges are never used
    assign k_rise = K_I & ~k_prev_reg;
    assign kn_rise = K_N_I & ~kn_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle definition
    ////////////////////////////////////////////////////////////////////////////
    // Low cycle-define at a true rise opens a burst; never looked at on K_N
    assign cycle_start = k_rise & ~CYCLE_DEFINE_N_I;

    // Address and direction caught together with cycle-define
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cycle_reg <= '{addr: dsc_pkg::ADDR_RESET, read: 1'b0};
        end else if (cycle_start) begin
            cycle_reg.addr <= ADDR_I;
            cycle_reg.read <= READ_NOT_WRITE_I;
        end
        // High cycle-define leaves the held definition untouched
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencing
    ////////////////////////////////////////////////////////////////////////////
    // Each burst: word 0 at the next K_N rise, word 1 at the following K rise.
    // The K rise that ends a burst may also define the next, so bursts chain.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dsc_pkg::DSC_IDLE: begin
                // Wait for a definition
                if (cycle_start) begin
                    state_next = READ_NOT_WRITE_I ? dsc_pkg::DSC_RD0 : dsc_pkg::DSC_WR0;
                end
            end
            dsc_pkg::DSC_WR0: begin
                // First write word at complement rise
                if (kn_rise) begin
                    state_next = dsc_pkg::DSC_WR1;
                end
            end
            dsc_pkg::DSC_RD0: begin
                // First read word at complement rise
                if (kn_rise) begin
                    state_next = dsc_pkg::DSC_RD1;
                end
            end
            dsc_pkg::DSC_WR1, dsc_pkg::DSC_RD1: begin
                // Second word at true rise; chain or go idle
                if (k_rise) begin
                    if (cycle_start) begin
                        state_next = READ_NOT_WRITE_I ? dsc_pkg::DSC_RD0 : dsc_pkg::DSC_WR0;
                    end else begin
                        state_next = dsc_pkg::DSC_IDLE;
                    end
                end
            end
            default: begin
                // Illegal code recovers to idle
                state_next = dsc_pkg::DSC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= dsc_pkg::DSC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write capture
    ////////////////////////////////////////////////////////////////////////////
    // Capture on complement rise for word 0 and true rise for word 1
    assign wr_cap = ((state_reg == dsc_pkg::DSC_WR0) && kn_rise) ||
                    ((state_reg == dsc_pkg::DSC_WR1) && k_rise);

    // Beat index follows the half of the burst being captured
    always_comb begin
        wr_word.addr = cycle_reg.addr;
        wr_word.data = DQ_I;
        if (state_reg == dsc_pkg::DSC_WR1) begin
            wr_word.beat = dsc_pkg::BEAT_SECOND;
        end else begin
            wr_word.beat = dsc_pkg::BEAT_FIRST;
        end
    end

    assign wr_word_bits = wr_word;

    // Words wait here so a busy array port never loses write data
    dsc_fifo #(
        .WIDTH(dsc_pkg::WR_WORD_W),
        .DEPTH(dsc_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i(MCLK_I),
        .rst_n_i(RESET_N_I),
        .in_valid_i(wr_cap),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wr_word_bits),
        .out_valid_o(drain_valid),
        .out_ready_i(drain_ready),
        .out_data_o(drain_bits)
    );

    assign drain_word = drain_bits;

    // Single array port: a read fetch takes priority and stalls the drain
    assign drain_ready = ~cycle_start | CYCLE_DEFINE_N_I | ~READ_NOT_WRITE_I;

    // Full FIFO is flagged to the controller side; further words would be lost
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= ~fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage array
    ////////////////////////////////////////////////////////////////////////////
    // Reads see a write only once it has drained; drain is one word a cycle,
    // far faster than the burst rate, so this is rarely visible
    dsc_array u_array (
        .clk_i(MCLK_I),
        .wr_en_i(drain_valid & drain_ready),
        .wr_word_i(drain_word),
        .rd_addr_i(ADDR_I),
        .rd_burst_o(rd_burst)
    );

    // Whole burst fetched at the read definition edge
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_burst_reg <= '0;
        end else if (cycle_start && READ_NOT_WRITE_I) begin
            rd_burst_reg <= rd_burst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read drive
    ////////////////////////////////////////////////////////////////////////////
    // Word 0 launched at complement rise, word 1 at true rise
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dq_reg <= dsc_pkg::DATA_RESET;
        end else if ((state_reg == dsc_pkg::DSC_RD0) && kn_rise) begin
            dq_reg <= rd_burst_reg[0 +: dsc_pkg::DATA_W];
        end else if ((state_reg == dsc_pkg::DSC_RD1) && k_rise) begin
            dq_reg <= rd_burst_reg[dsc_pkg::DATA_W +: dsc_pkg::DATA_W];
        end
    end

    // Enable tracks the read burst; it drops at the next K_N rise, or two cycles after the K rise when a write burst follows
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dq_oe_reg <= 1'b0;
        end else if (kn_rise) begin
            dq_oe_reg <= (state_reg == dsc_pkg::DSC_RD0);
        end else if (!is_read_state(state_reg) && is_write_state(state_reg)) begin
            dq_oe_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////
    assign DQ_O = dq_reg;
    assign DQ_OE_O = dq_oe_reg;
    assign WRITE_STALL_O = stall_reg;

endmodule : dsc_top

// ---- dsc_pkg.sv ----
// Shared constants and types for the burst SRAM data and cycle-define block
package dsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    ////////////////////////////////////////////////////////////////////////////
    // Data width per variant: 8, 9, 18 or 36; the x18 variant is built here
    localparam int DATA_W = 18;
    // Burst length of every transaction
    localparam int BURST_LEN = 2;
    // Width of the beat index inside a burst
    localparam int BEAT_W = 1;
    // Address width of the modelled array, kept small on purpose
    localparam int ADDR_W = 4;
    // Number of burst locations
    localparam int LOCATIONS = 16;
    // Depth of the write data FIFO
    localparam int FIFO_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and beat indices
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 1'h0;
    localparam logic [BEAT_W-1:0] BEAT_SECOND = 1'h1;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h0_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    ////////////////////////////////////////////////////////////////////////////
    // Data pin state within a burst
    typedef enum logic [2:0] {
        DSC_IDLE = 3'b000,
        DSC_WR0 = 3'b001,
        DSC_WR1 = 3'b010,
        DSC_RD0 = 3'b011,
        DSC_RD1 = 3'b100
    } dsc_state_e;

    // One captured write word on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BEAT_W-1:0] beat;
        logic [DATA_W-1:0] data;
    } dsc_wr_word_s;

    // Cycle definition taken at a true-clock edge
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic read;
    } dsc_cycle_s;

    localparam int WR_WORD_W = $bits(dsc_wr_word_s);

endpackage : dsc_pkg

// ---- dsc_fifo.sv ----
// Parameterised valid/ready FIFO for captured write words
`timescale 1ns/1ps
module dsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Storage and pointers
    ////////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] mem_reg [DEPTH];  // Word storage
    logic [PTR_W-1:0] wr_ptr_reg;  // Next slot to fill
    logic [PTR_W-1:0] rd_ptr_reg;  // Oldest word
    logic [PTR_W:0] count_reg;  // Words held
    logic push;
    logic pop;

    // Honest flags straight from the count; full is compared at count width so DEPTH is not cut
    assign in_ready_o = (count_reg != (PTR_W+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage write, no reset needed for data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointer and count bookkeeping
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (PTR_W+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (PTR_W+1)'(1);
            end
        end
    end

endmodule : dsc_fifo

// ---- dsc_array.sv ----
// Burst storage array: one write port, both words of a location read at once
`timescale 1ns/1ps
module dsc_array (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire dsc_pkg::dsc_wr_word_s wr_word_i,
    input wire logic [dsc_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [dsc_pkg::BURST_LEN*dsc_pkg::DATA_W-1:0] rd_burst_o
);
    // One bank per beat, so a whole burst reads in one cycle
    genvar b;
    generate
        for (b = 0; b < dsc_pkg::BURST_LEN; b++) begin : g_bank
            logic [dsc_pkg::DATA_W-1:0] bank_reg [dsc_pkg::LOCATIONS];  // Beat b words

            // Write only the bank that the beat index selects
            always_ff @(posedge clk_i) begin
                if (wr_en_i && (wr_word_i.beat == dsc_pkg::BEAT_W'(b))) begin
                    bank_reg[wr_word_i.addr] <= wr_word_i.data;
                end
            end

            // First beat sits in the low word
            assign rd_burst_o[b*dsc_pkg::DATA_W +: dsc_pkg::DATA_W] = bank_reg[rd_addr_i];
        end
    endgenerate

endmodule : dsc_array

// ---- dsc_top_sva.sv ----
// Concurrent checks on the data pins and cycle-define load
`timescale 1ns/1ps
module dsc_top_sva (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic K_I,
    input wire logic K_N_I,
    input wire logic CYCLE_DEFINE_N_I,
    input wire logic READ_NOT_WRITE_I,
    input wire logic [dsc_pkg::DATA_W-1:0] DQ_O,
    input wire logic DQ_OE_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper logic
    ////////////////////////////////////////////////////////////////////////////
    logic k_reg; // Last sampled true clock
    logic kn_reg; // Last sampled complementary clock
    logic rd_sel_reg; // Read defined at the last true-clock rise
    logic [1:0] k_cnt_reg; // True rises since the last complementary rise
    logic k_rise; // True clock rose
    logic kn_rise; // Complementary clock rose
    logic any_rise; // Either clock rose

    assign k_rise = K_I & ~k_reg;
    assign kn_rise = K_N_I & ~kn_reg;
    assign any_rise = k_rise | kn_rise;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // Edge history starts at idle levels, true clock low and complement high
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            k_reg <= 1'b0;
            kn_reg <= 1'b1;
        end else begin
            k_reg <= K_I;
            kn_reg <= K_N_I;
        end
    end

    // Read selection follows cycle-define only on true rises
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_sel_reg <= 1'b0;
        end else if (k_rise) begin
            rd_sel_reg <= ~CYCLE_DEFINE_N_I & READ_NOT_WRITE_I;
        end
    end

    // Saturating count, so a lost complementary rise cannot wrap to a pass
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            k_cnt_reg <= 2'h0;
        end else if (kn_rise) begin
            k_cnt_reg <= 2'h0;
        end else if (k_rise && k_cnt_reg != 2'h3) begin
            k_cnt_reg <= k_cnt_reg + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////
    chk_oe_follows_read: assert property (kn_rise |=> DQ_OE_O == rd_sel_reg)
        else $error("drive enable does not match read selection");
    chk_define_true_only: assert property (kn_rise && !CYCLE_DEFINE_N_I && !rd_sel_reg |=> !DQ_OE_O)
        else $error("cycle define taken on complementary rise");
    chk_oe_steady_krise: assert property (k_rise |=> $stable(DQ_OE_O))
        else $error("drive enable moved on a true rise");
    chk_dq_on_edges: assert property (!$stable(DQ_O) |-> $past(any_rise))
        else $error("read data changed away from a clock rise");
    chk_oe_rise_kn: assert property ($rose(DQ_OE_O) |-> $past(kn_rise))
        else $error("first read word not launched on complementary rise");
    chk_burst_two_beats: assert property (kn_rise && DQ_OE_O |-> k_cnt_reg == 2'h1)
        else $error("read burst is not two words");
    chk_read_drives: assert property (k_rise && !CYCLE_DEFINE_N_I && READ_NOT_WRITE_I |-> ##[3:16] DQ_OE_O)
        else $error("read define never drove the pins");
    chk_write_no_drive: assert property (k_rise && !CYCLE_DEFINE_N_I && !READ_NOT_WRITE_I
        |-> ##[1:16] kn_rise ##1 !DQ_OE_O)
        else $error("write burst drove the pins");
endmodule : dsc_top_sva

bind dsc_top dsc_top_sva u_sva (
    .MCLK_I(MCLK_I),
    .RESET_N_I(RESET_N_I),
    .K_I(K_I),
    .K_N_I(K_N_I),
    .CYCLE_DEFINE_N_I(CYCLE_DEFINE_N_I),
    .READ_NOT_WRITE_I(READ_NOT_WRITE_I),
    .DQ_O(DQ_O),
    .DQ_OE_O(DQ_OE_O)
);

// ---- dsc_ctl_model.sv ----
// Behavioural memory controller driving input clocks and commands
`timescale 1ns/1ps
module dsc_ctl_model (
    input wire logic clk_i,
    input wire logic [dsc_pkg::DATA_W-1:0] dq_i,
    input wire logic dq_oe_i,
    output logic k_o,
    output logic k_n_o,
    output logic cd_n_o,
    output logic [dsc_pkg::ADDR_W-1:0] addr_o,
    output logic rnw_o,
    output logic [dsc_pkg::DATA_W-1:0] dq_o
);
    // Idle: true clock low, nothing defined
    initial begin
        k_o = 1'b0;
        k_n_o = 1'b1;
        cd_n_o = 1'b1;
        addr_o = dsc_pkg::ADDR_RESET;
        rnw_o = 1'b0;
        dq_o = dsc_pkg::DATA_RESET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One half period of the input clocks, four system clocks long
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic k, input logic cd_n, input logic rnw, input logic [dsc_pkg::ADDR_W-1:0] a,
        input logic drv, input logic [dsc_pkg::DATA_W-1:0] d, output logic [dsc_pkg::DATA_W-1:0] q,
        output logic oe);
        @(posedge clk_i);
        k_o <= k;
        k_n_o <= ~k;
        cd_n_o <= cd_n;
        rnw_o <= rnw;
        addr_o <= a;
        // Released bus flips, so stale data never looks valid
        dq_o <= drv ? d : ~dq_o;
        repeat (3) @(posedge clk_i);
        #1;
        q = dq_i;
        oe = dq_oe_i;
    endtask : step
endmodule : dsc_ctl_model

// ---- dsc_top_tb.sv ----
// Self-checking bench for the data pins and cycle-define load
`timescale 1ns/1ps
module dsc_top_tb;
    localparam int DW = dsc_pkg::DATA_W;
    logic mclk; // System clock
    logic reset_n; // Active-low reset
    logic k; // True input clock
    logic k_n; // Complementary input clock
    logic cd_n; // Cycle define
    logic [3:0] addr; // Burst location
    logic rnw; // Direction
    logic [DW-1:0] dq_ctl; // Controller drive
    logic [DW-1:0] dq_bus; // Resolved pins
    logic [DW-1:0] dq_o; // Device drive
    logic dq_oe; // Device enable
    logic stall; // Write FIFO full
    int n_mismatch;
    int comparisons;
    logic [DW-1:0] m0 [16]; // Expected first words
    logic [DW-1:0] m1 [16]; // Expected second words
    logic pend; // A burst awaits its second beat
    logic pend_rd;
    logic [3:0] pend_a;
    logic [DW-1:0] pend_w1;
    logic [DW-1:0] q;
    logic oe;

    // Pins resolve to whoever enables its drivers
    assign dq_bus = dq_oe ? dq_o : dq_ctl;

    dsc_top DUT (.MCLK_I(mclk), .RESET_N_I(reset_n), .K_I(k), .K_N_I(k_n), .CYCLE_DEFINE_N_I(cd_n),
        .ADDR_I(addr), .READ_NOT_WRITE_I(rnw), .DQ_I(dq_bus), .DQ_O(dq_o), .DQ_OE_O(dq_oe),
        .WRITE_STALL_O(stall));
    dsc_ctl_model ctl (.clk_i(mclk), .dq_i(dq_bus), .dq_oe_i(dq_oe), .k_o(k), .k_n_o(k_n), .cd_n_o(cd_n),
        .addr_o(addr), .rnw_o(rnw), .dq_o(dq_ctl));

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // True rise carrying any pending second beat, then a complementary rise
    task automatic xfer(input logic def, input logic rd, input logic [3:0] a, input logic [DW-1:0] w0,
        input logic [DW-1:0] w1);
        ctl.step(1'b1, ~def, rd, a, pend & ~pend_rd, pend_w1, q, oe);
        // A write defined here deselects the read, so drivers turn off and the word shows on the drive side only
        check(DW'(oe), DW'(pend & pend_rd & ~(def & ~rd)));
        if (pend & pend_rd) check((def & ~rd) ? dq_o : q, m1[pend_a]);
        if (pend & ~pend_rd) m1[pend_a] = pend_w1;
        // Define held low and inputs flipped on the complementary rise
        ctl.step(1'b0, 1'b0, ~rd, ~a, def & ~rd, w0, q, oe);
        check(DW'(oe), DW'(def & rd));
        if (def & rd) check(q, m0[a]);
        if (def & ~rd) m0[a] = w0;
        pend = def;
        pend_rd = rd;
        pend_a = a;
        pend_w1 = w1;
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    ////////////////////////////////////////////////////////////////////////////
    // Back-to-back writes, write into read, read into read
    task automatic t_write_read;
        xfer(1'b1, 1'b0, 4'h3, 18'h1_2345, 18'h2_ABCD);
        xfer(1'b1, 1'b0, 4'h4, 18'h0_5A5A, 18'h3_A5A5);
        xfer(1'b1, 1'b1, 4'h3, 18'h0_0000, 18'h0_0000);
        xfer(1'b1, 1'b1, 4'h4, 18'h0_0000, 18'h0_0000);
        xfer(1'b0, 1'b0, 4'h0, 18'h0_0000, 18'h0_0000);
        check(DW'(stall), DW'(1'b0));
    endtask : t_write_read

    // Edge addresses and full-width words, read into write
    task automatic t_bounds;
        xfer(1'b1, 1'b0, 4'hF, 18'h3_FFFF, 18'h0_0000);
        xfer(1'b1, 1'b0, 4'h0, 18'h2_AAAA, 18'h1_5555);
        xfer(1'b1, 1'b1, 4'hF, 18'h0_0000, 18'h0_0000);
        xfer(1'b1, 1'b0, 4'h7, 18'h0_0001, 18'h2_0000);
        xfer(1'b1, 1'b1, 4'h0, 18'h0_0000, 18'h0_0000);
        xfer(1'b1, 1'b1, 4'h7, 18'h0_0000, 18'h0_0000);
        xfer(1'b0, 1'b0, 4'h0, 18'h0_0000, 18'h0_0000);
    endtask : t_bounds

    // High define with read inputs starts nothing
    task automatic t_no_define;
        xfer(1'b0, 1'b1, 4'h3, 18'h0_0000, 18'h0_0000);
        xfer(1'b1, 1'b1, 4'h4, 18'h0_0000, 18'h0_0000);
        xfer(1'b0, 1'b1, 4'hF, 18'h0_0000, 18'h0_0000);
    endtask : t_no_define

    // Reset in mid-read releases the pins at once
    task automatic t_reset;
        xfer(1'b1, 1'b1, 4'h3, 18'h0_0000, 18'h0_0000);
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(DW'(dq_oe), DW'(1'b0));
        check(dq_o, dsc_pkg::DATA_RESET);
        @(posedge mclk);
        reset_n <= 1'b1;
        pend = 1'b0;
        xfer(1'b1, 1'b1, 4'h4, 18'h0_0000, 18'h0_0000);
        xfer(1'b0, 1'b0, 4'h0, 18'h0_0000, 18'h0_0000);
    endtask : t_reset

    // Main sequence
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        pend = 1'b0;
        pend_rd = 1'b0;
        pend_a = 4'h0;
        pend_w1 = 18'h0_0000;
        reset_n = 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_write_read();
        t_bounds();
        t_no_define();
        t_reset();
        finish_test();
    end

    // Watchdog, far beyond the roughly 150 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
endmodule : dsc_top_tb
